// >>> hw/poc_pkg.sv
// package for the pwm output conditioning block: register map, field layout, carriers
// assumes a 32-bit axi4-lite register bus and a three-phase timing unit upstream
package poc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int MPW_W = 10;
    localparam int SEG_W = 9;
    localparam int CNT_W = 16;
    localparam int DIFF_W = CNT_W + 2;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_MIN_PULSE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_SEGMENT = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_SEG_ACTIVE = 12'h00C;

    // reset values
    localparam logic [MPW_W-1:0] MPW_RST = 10'h000;
    localparam logic [SEG_W-1:0] SEG_RST = 9'h000;

    // segment register fields, phase a at the top, b and c below it
    localparam int XOVER_A_BIT = 8;
    localparam int DIS_A_LO_BIT = 5;
    localparam int DIS_A_HI_BIT = 4;
    localparam int DIS_STRIDE = 2;

    // system status fields
    localparam int STAT_POL_BIT = 2;
    localparam int STAT_HALF_BIT = 3;
    localparam int STAT_SR_BIT = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // six gate signals of the three inverter legs
    typedef struct packed {
        logic a_hi;
        logic a_lo;
        logic b_hi;
        logic b_lo;
        logic c_hi;
        logic c_lo;
    } poc_gate_s;

    // duty, dead time and half period of the running half cycle
    typedef struct packed {
        logic [CNT_W-1:0] duty_phase_a;
        logic [CNT_W-1:0] duty_phase_b;
        logic [CNT_W-1:0] duty_phase_c;
        logic [CNT_W-1:0] dead_time_count;
        logic [CNT_W-1:0] half_period_count;
    } poc_timing_s;

endpackage : poc_pkg

// >>> hw/poc_pwm_output_conditioning.sv
// pwm output conditioning: pulse deletion, reluctance override, crossover,
// per-output disable and polarity, with an axi4-lite register slave.
// assumes timing-unit inputs synchronous to core_clk and held over each half cycle.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
module poc_pwm_output_conditioning (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [poc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [poc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [poc_pkg::STRB_W-1:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [poc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [poc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // timing unit
    input wire poc_pkg::poc_gate_s tu_gate_n,
    input wire poc_pkg::poc_timing_s tu_timing,
    input wire logic pwm_sync_pulse,
    input wire logic second_half,
    // pins
    input wire logic reluctance_select_n,
    input wire logic output_polarity_pin,
    // gate outputs
    output poc_pkg::poc_gate_s gate_out
);

    // gate path, one register deep:
    //   timing-unit levels -> deletion and reluctance override
    //   -> crossover -> per-pin disable -> polarity -> gate_q
    // register path: axi4-lite slave with fixed answers
    //   write answered two cycles after the later half is taken
    //   read answered the cycle after the address is taken

    // registers
    logic [poc_pkg::MPW_W-1:0] mpw_q;
    logic [poc_pkg::SEG_W-1:0] seg_pend_q;
    logic [poc_pkg::SEG_W-1:0] seg_act_q;
    logic sync_q;
    poc_pkg::poc_gate_s gate_q;

    // bus state
    // write address and data are parked until both are in,
    // then applied in one cycle and answered the next
    logic awready_q;
    logic wready_q;

    // parked write request
    logic aw_hold_q;
    logic w_hold_q;
    logic [poc_pkg::ADDR_W-1:0] waddr_q;
    logic [poc_pkg::DATA_W-1:0] wdata_q;
    logic [poc_pkg::STRB_W-1:0] wstrb_q;

    // write response
    logic bvalid_q;
    logic [1:0] bresp_q;

    // read path, one word in flight
    logic arready_q;
    logic rvalid_q;
    logic [poc_pkg::DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // bus decode
    wire aw_hs = s_axi_awvalid & awready_q;
    wire w_hs = s_axi_wvalid & wready_q;
    wire ar_hs = s_axi_arvalid & arready_q;
    wire b_hs = bvalid_q & s_axi_bready;
    wire r_hs = rvalid_q & s_axi_rready;

    // a parked pair is applied once, while no response waits
    wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
    wire wr_mpw = do_write & (waddr_q == poc_pkg::ADDR_MIN_PULSE);
    wire wr_seg = do_write & (waddr_q == poc_pkg::ADDR_SEGMENT);

    // status and active copy accept writes but ignore them
    wire wr_ro = (waddr_q == poc_pkg::ADDR_STATUS) | (waddr_q == poc_pkg::ADDR_SEG_ACTIVE);
    // unmapped offsets answer with an error
    wire wr_ok =
        (waddr_q == poc_pkg::ADDR_MIN_PULSE) |
        (waddr_q == poc_pkg::ADDR_SEGMENT) |
        wr_ro;

    // byte-lane merge of write data
    // each strobe bit keeps or replaces one byte of the stored value
    logic [poc_pkg::DATA_W-1:0] strb_mask;
    always_comb begin
        for (int i = 0; i < poc_pkg::STRB_W; i++) begin
            strb_mask[i*8 +: 8] = {8{wstrb_q[i]}};
        end
    end
    wire [poc_pkg::DATA_W-1:0] mpw_merged =
        ({{(poc_pkg::DATA_W-poc_pkg::MPW_W){1'b0}}, mpw_q} & ~strb_mask) | (wdata_q & strb_mask);

    wire [poc_pkg::DATA_W-1:0] seg_merged =
        ({{(poc_pkg::DATA_W-poc_pkg::SEG_W){1'b0}}, seg_pend_q} & ~strb_mask)
        | (wdata_q & strb_mask);

    // status word: polarity, half cycle and reluctance pin levels
    // pins are read live, as they stand when the read address is taken
    wire [poc_pkg::DATA_W-1:0] status_word =
        ({{(poc_pkg::DATA_W-1){1'b0}}, output_polarity_pin} << poc_pkg::STAT_POL_BIT)
        | ({{(poc_pkg::DATA_W-1){1'b0}}, second_half} << poc_pkg::STAT_HALF_BIT)
        | ({{(poc_pkg::DATA_W-1){1'b0}}, reluctance_select_n} << poc_pkg::STAT_SR_BIT);

    // read selection
    wire rd_mpw = (s_axi_araddr == poc_pkg::ADDR_MIN_PULSE);
    wire rd_seg = (s_axi_araddr == poc_pkg::ADDR_SEGMENT);
    wire rd_stat = (s_axi_araddr == poc_pkg::ADDR_STATUS);
    wire rd_act = (s_axi_araddr == poc_pkg::ADDR_SEG_ACTIVE);
    wire rd_ok = rd_mpw | rd_seg | rd_stat | rd_act;

    // unmapped read offsets return zero with an error response
    wire [poc_pkg::DATA_W-1:0] rd_mux =
        ({poc_pkg::DATA_W{rd_mpw}} & {{(poc_pkg::DATA_W-poc_pkg::MPW_W){1'b0}}, mpw_q})
        | ({poc_pkg::DATA_W{rd_seg}} & {{(poc_pkg::DATA_W-poc_pkg::SEG_W){1'b0}}, seg_pend_q})
        | ({poc_pkg::DATA_W{rd_act}} & {{(poc_pkg::DATA_W-poc_pkg::SEG_W){1'b0}}, seg_act_q})
        | ({poc_pkg::DATA_W{rd_stat}} & status_word);

    // sync boundary; the timing unit also pulses sync at the midpoint in double update
    // sync is a level; only its rising edge counts, so a wide pulse
    // loads the active segment once
    wire sync_rise = pwm_sync_pulse & ~sync_q;

    // write address capture, in either order with the data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
            aw_hold_q <= 1'b0;
            waddr_q <= '0;
        end else if (clk_en) begin
            if (aw_hs) begin
                awready_q <= 1'b0;
                aw_hold_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end else if (b_hs) begin
                awready_q <= 1'b1;
            end
        end
    end

    // write data capture, same life cycle as the address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wready_q <= 1'b1;
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (clk_en) begin
            if (w_hs) begin
                wready_q <= 1'b0;
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end else if (b_hs) begin
                wready_q <= 1'b1;
            end
        end
    end

    // write response
    // bresp is settled with bvalid and holds until bready
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= poc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? poc_pkg::RESP_OKAY : poc_pkg::RESP_SLVERR;
            end else if (b_hs) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel
    // read data is captured with the address and stands until taken
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= poc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? poc_pkg::RESP_OKAY : poc_pkg::RESP_SLVERR;
            end else if (r_hs) begin
                arready_q <= 1'b1;
                rvalid_q <= 1'b0;
            end
        end
    end

    // software registers; no bit here selects reluctance mode
    // min width and pending segment take writes at once; the segment
    // reaches the outputs only through the sync-loaded active copy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mpw_q <= poc_pkg::MPW_RST;
            seg_pend_q <= poc_pkg::SEG_RST;
        end else if (clk_en) begin
            if (wr_mpw) begin
                mpw_q <= mpw_merged[poc_pkg::MPW_W-1:0];
            end
            if (wr_seg) begin
                seg_pend_q <= seg_merged[poc_pkg::SEG_W-1:0];
            end
        end
    end

    // active segment loads only on a sync rising edge
    // a write and a sync rise in one cycle: the old pending value loads,
    // the new one waits for the next sync
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 1'b0;
            seg_act_q <= poc_pkg::SEG_RST;
        end else if (clk_en) begin
            sync_q <= pwm_sync_pulse;
            if (sync_rise) begin
                seg_act_q <= seg_pend_q;
            end
        end
    end

    // on-time check against minimum; returns {delete high, delete low}
    function automatic logic [1:0] poc_delete(
        input logic [poc_pkg::CNT_W-1:0] duty,
        input logic [poc_pkg::CNT_W-1:0] dead,
        input logic [poc_pkg::CNT_W-1:0] half,
        input logic [poc_pkg::MPW_W-1:0] mpw
    );
        logic signed [poc_pkg::DIFF_W-1:0] on_hi;
        logic signed [poc_pkg::DIFF_W-1:0] on_lo;
        logic signed [poc_pkg::DIFF_W-1:0] limit;
        // widened and signed so that dead time larger than duty
        // reads as a negative on-time and is deleted whenever the minimum width is non-zero
        on_hi = $signed({2'h0, duty}) - $signed({2'h0, dead});
        on_lo = $signed({2'h0, half}) - $signed({2'h0, duty}) - $signed({2'h0, dead});
        limit = $signed({{(poc_pkg::DIFF_W-poc_pkg::MPW_W){1'b0}}, mpw});

        // zero minimum width never deletes
        poc_delete[1] = (mpw != '0) && (on_hi < limit);
        poc_delete[0] = (mpw != '0) && (on_lo < limit);
    endfunction : poc_delete

    // per-phase arrays, index 0 = a, 1 = b, 2 = c
    // timing-unit signals are active low; flipped once to on-levels here
    logic [2:0] tu_hi_on;
    logic [2:0] tu_lo_on;
    logic [poc_pkg::CNT_W-1:0] duty_arr [3];
    assign tu_hi_on = ~{tu_gate_n.c_hi, tu_gate_n.b_hi, tu_gate_n.a_hi};
    assign tu_lo_on = ~{tu_gate_n.c_lo, tu_gate_n.b_lo, tu_gate_n.a_lo};
    assign duty_arr[0] = tu_timing.duty_phase_a;
    assign duty_arr[1] = tu_timing.duty_phase_b;
    assign duty_arr[2] = tu_timing.duty_phase_c;

    // pin levels per phase, after every stage
    logic [2:0] pin_hi;
    logic [2:0] pin_lo;

    // reluctance mode follows the pin only
    wire sr_mode = ~reluctance_select_n;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        // stage 1: minimum pulse deletion on the timing-unit pair
        wire [1:0] del = poc_delete(duty_arr[p], tu_timing.dead_time_count,
                                    tu_timing.half_period_count, mpw_q);
        // deletion: high short wins, then low short
        wire hi_del = del[1] ? 1'b0 : (del[0] ? 1'b1 : tu_hi_on[p]);
        wire lo_del = del[1] ? 1'b1 : (del[0] ? 1'b0 : tu_lo_on[p]);

        // stage 2: reluctance override keeps the low side on
        wire lo_sr = lo_del | sr_mode;

        // stage 3: crossover swaps the pair before the pins
        wire xo = seg_act_q[poc_pkg::XOVER_A_BIT - p];
        wire hi_x = xo ? lo_sr : hi_del;
        wire lo_x = xo ? hi_del : lo_sr;

        // stage 4: disable acts on the pin, after crossover
        wire dis_hi = seg_act_q[poc_pkg::DIS_A_HI_BIT - poc_pkg::DIS_STRIDE * p];
        wire dis_lo = seg_act_q[poc_pkg::DIS_A_LO_BIT - poc_pkg::DIS_STRIDE * p];

        // stage 5: on level per polarity pin, off when disabled
        assign pin_hi[p] = (hi_x & ~dis_hi) ~^ output_polarity_pin;
        assign pin_lo[p] = (lo_x & ~dis_lo) ~^ output_polarity_pin;
    end

    poc_pkg::poc_gate_s gate_d;
    // pin levels back into the carrier, phase a first
    assign gate_d = '{
        a_hi: pin_hi[0],
        a_lo: pin_lo[0],
        b_hi: pin_hi[1],
        b_lo: pin_lo[1],
        c_hi: pin_hi[2],
        c_lo: pin_lo[2]
    };

    // gate pins leave straight from flops, one clock behind the inputs
    // reset level is 0, the off level only while polarity is high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_q <= '0;
        end else if (clk_en) begin
            gate_q <= gate_d;
        end
    end

    // write channel outputs
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // read channel outputs
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // gate pins
    assign gate_out = gate_q;

endmodule : poc_pwm_output_conditioning

// >>> verif/poc_gate_driver_model.sv
// gate driver stand-in: turns the six pin levels into switch on states
// assumes it sees the same polarity pin level as the block
module poc_gate_driver_model (
    // pins from the block
    input wire poc_pkg::poc_gate_s gate_out,
    input wire logic output_polarity_pin,
    // power switch states, 1 = conducting
    output poc_pkg::poc_gate_s switch_on
);
    timeunit 1ns;
    timeprecision 1ps;
    assign switch_on = output_polarity_pin ? gate_out : ~gate_out;
endmodule : poc_gate_driver_model

// >>> verif/poc_monitor.sv
// checker: bus handshakes and gate pin relations of the output conditioning block
// assumes clk_en held high and full-word writes with address and data together
module poc_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [poc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [poc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [poc_pkg::DATA_W-1:0] s_axi_rdata,
    // gate path
    input wire poc_pkg::poc_gate_s tu_gate_n,
    input wire poc_pkg::poc_timing_s tu_timing,
    input wire logic pwm_sync_pulse,
    input wire logic reluctance_select_n,
    input wire logic output_polarity_pin,
    input wire poc_pkg::poc_gate_s gate_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] pend_q;
    logic [8:0] act_q;
    logic [9:0] mpw_q;
    logic [31:0] wd_q;
    logic [11:0] wa_q;
    logic wr_q;
    logic sy_q;
    wire wr_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    wire sy_rise = pwm_sync_pulse & ~sy_q;
    wire pol = output_polarity_pin;
    wire signed [17:0] on_a = 18'(tu_timing.duty_phase_a) - 18'(tu_timing.dead_time_count);
    // shadow of written and sync-loaded registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {pend_q, act_q, mpw_q, wd_q, wa_q, wr_q, sy_q} <= '0;
        end else begin
            {wr_q, wd_q, wa_q, sy_q} <= {wr_take, s_axi_wdata, s_axi_awaddr, pwm_sync_pulse};
            if (wr_q && wa_q == poc_pkg::ADDR_SEGMENT) pend_q <= wd_q[8:0];
            if (wr_q && wa_q == poc_pkg::ADDR_MIN_PULSE) mpw_q <= wd_q[9:0];
            if (sy_rise) act_q <= pend_q;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_resp;
        ##1 !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    chk_b_after_wr: assert property (wr_take |-> wr_resp)
        else $error("write response timing off");
    chk_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_dis_a_hi: assert property (act_q[4] |=> gate_out.a_hi == !$past(pol))
        else $error("disabled output not off");
    chk_xover_a_lo: assert property ((mpw_q == 0 && act_q[8] && !act_q[5]) |=>
        gate_out.a_lo == ($past(tu_gate_n.a_hi) ^ $past(pol)))
        else $error("crossover path wrong");
    chk_sr_low_on: assert property ((!reluctance_select_n && !act_q[8] && !act_q[5]) |=>
        gate_out.a_lo == $past(pol))
        else $error("low side not forced on");
    chk_pass_b_hi: assert property ((mpw_q == 0 && !act_q[7] && !act_q[2]) |=>
        gate_out.b_hi == ($past(tu_gate_n.b_hi) ^ $past(pol)))
        else $error("high side path wrong");
    chk_del_a_hi: assert property ((mpw_q != 0 && !act_q[8] && act_q[5:4] == 2'h0
        && on_a < $signed({8'h00, mpw_q})) |=>
        gate_out.a_hi == !$past(pol) && gate_out.a_lo == $past(pol))
        else $error("short pulse not deleted");
endmodule : poc_monitor

// >>> verif/pwm_output_conditioning_bench.sv
// bench: register bus access, sync-latched segment, random gate traffic
// assumes design, package, gate driver model and monitor compiled first
module pwm_output_conditioning_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic pwm_sync_pulse, second_half, reluctance_select_n, output_polarity_pin;
    logic [poc_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] mw;
    logic [8:0] sg;
    poc_pkg::poc_gate_s tu_gate_n, gate_out, switch_on;
    poc_pkg::poc_timing_s tu_timing;
    int n_fail, total_checks, seed;
    poc_pwm_output_conditioning u_poc_pwm_output_conditioning (.core_clk, .rst_n, .clk_en,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tu_gate_n, .tu_timing, .pwm_sync_pulse,
        .second_half, .reluctance_select_n, .output_polarity_pin, .gate_out);
    poc_gate_driver_model u_poc_gate_driver_model (.gate_out, .output_polarity_pin, .switch_on);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        int i;
        {s_axi_awvalid, s_axi_awaddr, s_axi_awprot} <= {1'b1, a, 3'($random(seed))};
        {s_axi_wvalid, s_axi_wdata, s_axi_wstrb} <= {1'b1, d, st};
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= (i > 1);
        end
        s_axi_bready <= 1'b0;
        if (i == 40) n_fail++;
        if (i == 40) close_out();
        chk("bresp", 32'(s_axi_bresp), 32'(er));
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        int i;
        {s_axi_arvalid, s_axi_araddr, s_axi_arprot} <= {1'b1, a, 3'($random(seed))};
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= (i > 0);
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (i == 40) n_fail++;
        if (i == 40) close_out();
        chk("rresp", 32'(s_axi_rresp), 32'(er));
        @(posedge core_clk);
    endtask : rd
    task automatic sync(input logic h);
        {pwm_sync_pulse, second_half} <= {1'b1, h};
        @(posedge core_clk);
        pwm_sync_pulse <= 1'b0;
        @(posedge core_clk);
    endtask : sync
    // expected switch states of one half cycle
    function automatic logic [5:0] exp_on(logic [5:0] t, logic [79:0] m, logic [9:0] w,
                                          logic [8:0] s, logic sr_n);
        logic [5:0] r;
        int oh, ol;
        logic hi, lo;
        for (int p = 0; p < 3; p++) begin
            oh = int'(m[79-16*p -: 16]) - int'(m[31:16]);
            ol = int'(m[15:0]) - int'(m[79-16*p -: 16]) - int'(m[31:16]);
            {hi, lo} = ~{t[5-2*p], t[4-2*p]};
            if (w != 0 && oh < int'(w)) begin
                {hi, lo} = 2'b01;
            end else if (w != 0 && ol < int'(w)) begin
                {hi, lo} = 2'b10;
            end
            lo = lo | ~sr_n;
            if (s[8-p]) begin
                {hi, lo} = {lo, hi};
            end
            r[5-2*p] = hi & ~s[4-2*p];
            r[4-2*p] = lo & ~s[5-2*p];
        end
        return r;
    endfunction : exp_on
    initial begin
        {seed, n_fail, total_checks} = {32'd56, 32'd0, 32'd0};
        {rst_n, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h10;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, s_axi_wstrb, tu_gate_n, tu_timing} = {32'h0, 4'hF, 6'h3F, 80'h0};
        {pwm_sync_pulse, second_half, reluctance_select_n, output_polarity_pin} = 4'h3;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(poc_pkg::ADDR_MIN_PULSE, poc_pkg::RESP_OKAY, v);
        chk("min width reset", v, 32'h0);
        rd(poc_pkg::ADDR_SEGMENT, poc_pkg::RESP_OKAY, v);
        chk("segment reset", v, 32'h0);
        wr(poc_pkg::ADDR_MIN_PULSE, 32'hFFFFFFFF, 4'hF, poc_pkg::RESP_OKAY);
        rd(poc_pkg::ADDR_MIN_PULSE, poc_pkg::RESP_OKAY, v);
        chk("min width", v, 32'h3FF);
        wr(poc_pkg::ADDR_MIN_PULSE, 32'h0, 4'hF, poc_pkg::RESP_OKAY);
        wr(poc_pkg::ADDR_MIN_PULSE, 32'hFFFFFFFF, 4'h2, poc_pkg::RESP_OKAY);
        rd(poc_pkg::ADDR_MIN_PULSE, poc_pkg::RESP_OKAY, v);
        chk("min width strobe", v, 32'h300);
        wr(poc_pkg::ADDR_SEGMENT, 32'hFFFFFFFF, 4'hF, poc_pkg::RESP_OKAY);
        rd(poc_pkg::ADDR_SEGMENT, poc_pkg::RESP_OKAY, v);
        chk("segment", v, 32'h1FF);
        rd(poc_pkg::ADDR_SEG_ACTIVE, poc_pkg::RESP_OKAY, v);
        chk("active before sync", v, 32'h0);
        sync(1'b0);
        rd(poc_pkg::ADDR_SEG_ACTIVE, poc_pkg::RESP_OKAY, v);
        chk("active after sync", v, 32'h1FF);
        wr(poc_pkg::ADDR_SEGMENT, 32'h0A7, 4'hF, poc_pkg::RESP_OKAY);
        sync(1'b1);
        rd(poc_pkg::ADDR_SEG_ACTIVE, poc_pkg::RESP_OKAY, v);
        chk("active midpoint", v, 32'h0A7);
        wr(poc_pkg::ADDR_STATUS, 32'hFFFFFFFF, 4'hF, poc_pkg::RESP_OKAY);
        for (int s = 0; s < 2; s++) begin
            reluctance_select_n <= s[0];
            repeat (3) @(posedge core_clk);
            rd(poc_pkg::ADDR_STATUS, poc_pkg::RESP_OKAY, v);
            chk("status", 32'({v[4], v[3], v[2]}), 32'({s[0], 2'b11}));
        end
        wr(12'h010, 32'h1, 4'hF, poc_pkg::RESP_SLVERR);
        rd(12'h010, poc_pkg::RESP_SLVERR, v);
        chk("unmapped", v, 32'h0);
        for (int k = 0; k < 40; k++) begin
            mw = (k < 2) ? 10'h000 : 10'($random(seed)) & 10'h007;
            sg = (k < 4) ? 9'h000 : 9'($random(seed));
            wr(poc_pkg::ADDR_MIN_PULSE, 32'(mw), 4'hF, poc_pkg::RESP_OKAY);
            wr(poc_pkg::ADDR_SEGMENT, 32'(sg), 4'hF, poc_pkg::RESP_OKAY);
            sync(k[0]);
            for (int j = 0; j < 12; j++) begin
                v = $random(seed);
                tu_gate_n <= 6'($random(seed));
                tu_timing <= {12'h0, v[3:0], 12'h0, v[7:4], 12'h0, v[11:8], 14'h0, v[13:12],
                              12'h001, v[17:14]};
                {reluctance_select_n, output_polarity_pin} <= v[19:18];
                @(posedge core_clk);
                @(negedge core_clk);
                chk("switches", 32'(switch_on), 32'(exp_on(tu_gate_n, tu_timing, mw, sg,
                    reluctance_select_n)));
                @(posedge core_clk);
            end
        end
        close_out();
    end
endmodule : pwm_output_conditioning_bench
bind poc_pwm_output_conditioning poc_monitor u_poc_monitor (.core_clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .tu_gate_n, .tu_timing, .pwm_sync_pulse, .reluctance_select_n,
    .output_polarity_pin, .gate_out);
